// file: pkg/sgel_pkg.sv
package sgel_pkg;
   localparam logic [15:0] SGEL_OFF_PME_STS1 = 16'h000c;
   localparam logic [15:0] SGEL_OFF_SMI_STS1 = 16'h0012;
   localparam logic [15:0] SGEL_OFF_SMI_STS2 = 16'h0013;
   localparam logic [15:0] SGEL_OFF_EN_ONE   = 16'h0014;
   localparam logic [15:0] SGEL_OFF_EN_TWO   = 16'h0015;

   localparam logic [7:0]  SGEL_RESET_VAL    = 8'h00;
   localparam logic [7:0]  SGEL_UNMAPPED_VAL = 8'h00;

   // smi_source_enable_one bit positions
   localparam int SGEL_E1_RING     = 0;
   localparam int SGEL_E1_PARALLEL = 1;
   localparam int SGEL_E1_SERIAL2  = 2;
   localparam int SGEL_E1_SERIAL1  = 3;
   localparam int SGEL_E1_FLOPPY   = 4;
   localparam int SGEL_E1_GPIO2    = 5;
   localparam int SGEL_E1_GPIO1    = 6;
   localparam int SGEL_E1_WATCHDOG = 7;

   // smi_source_enable_two bit positions
   localparam int SGEL_E2_KEYBOARD = 1;
   localparam int SGEL_E2_INFRARED = 2;
   localparam int SGEL_E2_B_SOURCE = 3;
   localparam int SGEL_E2_KBC_P12  = 4;
   localparam int SGEL_E2_CIR      = 5;
   localparam int SGEL_E2_TO_WAKE  = 6;
   localparam int SGEL_E2_OUTPUT   = 7;

   // smi status two bit positions
   localparam int SGEL_S2_MOUSE    = 0;
   localparam int SGEL_S2_KEYBOARD = 1;
   localparam int SGEL_S2_INFRARED = 2;
   localparam int SGEL_S2_B_SOURCE = 3;
   localparam int SGEL_S2_KBC_P12  = 4;

   // wake status one bit positions
   localparam int SGEL_P1_CIR      = 0;
   localparam int SGEL_P1_RING     = 5;
endpackage

// file: logic/sgel_sticky.sv
`timescale 1ns/1ns
module sgel_sticky
   import sgel_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clr,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   // set wins so an event in the clearing cycle is kept
   assign q_nxt = set | (q_r & ~clr);
   assign q     = q_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule

// file: logic/sgel_group.sv
`timescale 1ns/1ns
module sgel_group
   import sgel_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [15:0] power_block_base,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   input  wire logic        parallel_irq,
   input  wire logic        serial_two_irq,
   input  wire logic        serial_one_irq,
   input  wire logic        floppy_irq,
   input  wire logic        gpio_group_two_irq,
   input  wire logic        gpio_group_one_irq,
   input  wire logic        watchdog_irq,
   input  wire logic        mouse_irq,
   input  wire logic        keyboard_irq,
   input  wire logic        infrared_edge_event,
   input  wire logic        b_source_event,
   input  wire logic        kbc_port_one_bit_two,
   input  wire logic        ring_wake_event,
   input  wire logic        cir_wake_event,
   input  wire logic        serial_frame_select,
   output logic             group_mgmt_irq_n_o,
   output logic             group_mgmt_irq_n_oe,
   output logic             serirq_slot2_req,
   output logic             group_to_wake_req
);
   function automatic logic hit(input logic [15:0] addr,
                                input logic [15:0] base,
                                input logic [15:0] off);
      logic [15:0] rel;
      rel = addr - base;
      return rel == off;
   endfunction

   logic [7:0] en_one_r;
   logic [7:0] en_one_nxt;
   logic [7:0] en_two_r;
   logic [7:0] en_two_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       pin_r;
   logic       pin_oe_r;
   logic       slot_r;
   logic       wake_r;

   wire hit_en_one = hit(io_addr, power_block_base, SGEL_OFF_EN_ONE);
   wire hit_en_two = hit(io_addr, power_block_base, SGEL_OFF_EN_TWO);
   wire hit_sts1   = hit(io_addr, power_block_base, SGEL_OFF_SMI_STS1);
   wire hit_sts2   = hit(io_addr, power_block_base, SGEL_OFF_SMI_STS2);
   wire hit_pme1   = hit(io_addr, power_block_base, SGEL_OFF_PME_STS1);

   // infrared and b latches: read of status two clears them
   logic [1:0] smi_latch;
   wire  [1:0] smi_set = {b_source_event, infrared_edge_event};
   wire  [1:0] smi_clr = {2{io_rd & hit_sts2}};

   sgel_sticky #(.WIDTH(2)) u_smi_latch (
      .clk    (clk),
      .resetn (resetn),
      .set    (smi_set),
      .clr    (smi_clr),
      .q      (smi_latch)
   );

   // ring and consumer infrared wake status, write one to clear
   logic [1:0] wake_sts;
   wire  [1:0] wake_set = {ring_wake_event, cir_wake_event};
   wire  [1:0] wake_clr = {2{io_wr & hit_pme1}} &
                          {io_wdata[SGEL_P1_RING], io_wdata[SGEL_P1_CIR]};

   sgel_sticky #(.WIDTH(2)) u_wake_sts (
      .clk    (clk),
      .resetn (resetn),
      .set    (wake_set),
      .clr    (wake_clr),
      .q      (wake_sts)
   );

   wire ring_sts = wake_sts[1];
   wire cir_sts  = wake_sts[0];
   wire ir_sts   = smi_latch[0];
   wire b_sts    = smi_latch[1];

   // status one holds live source levels cleared at the source; the infrared, b, ring and cir bits are latched and cleared here
   wire [7:0] sts_one = {watchdog_irq, gpio_group_one_irq, gpio_group_two_irq,
                         floppy_irq, serial_one_irq, serial_two_irq,
                         parallel_irq, 1'b0};
   wire [7:0] sts_two = {3'b000, kbc_port_one_bit_two, b_sts, ir_sts,
                         keyboard_irq, mouse_irq};
   wire [7:0] pme_one = {2'b00, ring_sts, 4'b0000, cir_sts};

   // bit 0 of enable one uses the ring wake status in place of a status bit
   wire [7:0] src_one = {sts_one[7:1], ring_sts};
   wire [7:0] gated_one = src_one & en_one_r;

   wire kbd_g  = en_two_r[SGEL_E2_KEYBOARD] & keyboard_irq;
   wire ir_g   = en_two_r[SGEL_E2_INFRARED] & ir_sts;
   wire b_g    = en_two_r[SGEL_E2_B_SOURCE] & b_sts;
   wire p12_g  = en_two_r[SGEL_E2_KBC_P12] & kbc_port_one_bit_two;
   wire cir_g  = en_two_r[SGEL_E2_CIR] & cir_sts;

   wire group_active = (|gated_one) | kbd_g | ir_g | b_g | p12_g | cir_g;

   wire out_en   = en_two_r[SGEL_E2_OUTPUT];
   wire to_pin   = out_en & ~serial_frame_select;
   wire to_slot  = out_en & serial_frame_select;
   wire to_wake  = en_two_r[SGEL_E2_TO_WAKE] & group_active;

   assign en_one_nxt = (io_wr & hit_en_one) ? io_wdata : en_one_r;
   assign en_two_nxt = (io_wr & hit_en_two) ? io_wdata : en_two_r;

   assign rdata_nxt = !io_rd     ? rdata_r :
                      hit_en_one ? en_one_r :
                      hit_en_two ? en_two_r :
                      hit_sts1   ? sts_one :
                      hit_sts2   ? sts_two :
                      hit_pme1   ? pme_one : SGEL_UNMAPPED_VAL;

   // resetn is the battery power-on reset, so enables survive other resets
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_one_r <= SGEL_RESET_VAL;
         en_two_r <= SGEL_RESET_VAL;
      end else begin
         en_one_r <= en_one_nxt;
         en_two_r <= en_two_nxt;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= SGEL_RESET_VAL;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // one register stage on every output, so the irq lags a live source level by one clock and a latched event by two
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_r    <= 1'b1;
         pin_oe_r <= 1'b0;
         slot_r   <= 1'b0;
         wake_r   <= 1'b0;
      end else begin
         pin_r    <= ~(group_active & to_pin);
         pin_oe_r <= to_pin;
         slot_r   <= group_active & to_slot;
         wake_r   <= to_wake;
      end
   end

   assign io_rdata            = rdata_r;
   assign group_mgmt_irq_n_o  = pin_r;
   assign group_mgmt_irq_n_oe = pin_oe_r;
   assign serirq_slot2_req    = slot_r;
   assign group_to_wake_req   = wake_r;
endmodule

// file: dv/sgel_group_chk.sv
`timescale 1ns/1ns
module sgel_group_chk
   import sgel_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [15:0] power_block_base,
   input wire logic [15:0] io_addr,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic [7:0]  io_wdata,
   input wire logic [7:0]  io_rdata,
   input wire logic        serial_frame_select,
   input wire logic        group_mgmt_irq_n_o,
   input wire logic        group_mgmt_irq_n_oe,
   input wire logic        serirq_slot2_req,
   input wire logic        group_to_wake_req
);
   logic [15:0] off;
   logic        w15;
   assign off = io_addr - power_block_base;
   assign w15 = io_wr && off == SGEL_OFF_EN_TWO;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_pin_slot_excl: assert property (!(group_mgmt_irq_n_oe && serirq_slot2_req))
      else $error("pin and slot driven together");
   a_oe_pin_sel: assert property (group_mgmt_irq_n_oe |-> !$past(serial_frame_select))
      else $error("pin driven while slot selected");
   a_slot_sel: assert property (serirq_slot2_req |-> $past(serial_frame_select))
      else $error("slot request while pin selected");
   a_idle_high: assert property (!group_mgmt_irq_n_oe |-> group_mgmt_irq_n_o)
      else $error("pin low while undriven");
   a_en_readback: assert property (io_wr && off == SGEL_OFF_EN_ONE ##1 io_rd && !io_wr &&
      off == SGEL_OFF_EN_ONE |=> io_rdata == $past(io_wdata, 2)) else $error("enable readback");
   a_unmapped_zero: assert property (io_rd && off == 16'h0020 |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without read");
   a_wake_off: assert property (w15 && !io_wdata[6] ##1 !w15 [*2] |=> !group_to_wake_req)
      else $error("wake request with bit six clear");
   a_output_off: assert property (w15 && !io_wdata[7] ##1 !w15 [*2] |=>
      !group_mgmt_irq_n_oe && !serirq_slot2_req) else $error("output with bit seven clear");
   c_slot: cover property (serirq_slot2_req);
   c_pin_low: cover property (group_mgmt_irq_n_oe && !group_mgmt_irq_n_o);
   c_wake: cover property (group_to_wake_req);
endmodule
bind sgel_group sgel_group_chk i_chk (.clk, .resetn, .power_block_base, .io_addr, .io_wr,
   .io_rd, .io_wdata, .io_rdata, .serial_frame_select, .group_mgmt_irq_n_o,
   .group_mgmt_irq_n_oe, .serirq_slot2_req, .group_to_wake_req);

// file: dv/sgel_host_model.sv
`timescale 1ns/1ns
module sgel_host_model (
   input  wire logic clk,
   input  wire logic irq_n_o,
   input  wire logic oe,
   input  wire logic slot,
   output logic      pin_level,
   output logic      smi_seen
);
   logic last_r = 1'b1;
   always @(posedge clk) if (oe) last_r <= irq_n_o;
   // no pull-up on the board: a released pin shows the inverse of its last level
   assign pin_level = oe ? irq_n_o : ~last_r;
   assign smi_seen = (oe && !pin_level) || slot;
endmodule

// file: dv/sgel_group_bench.sv
`timescale 1ns/1ns
module sgel_group_bench
   import sgel_pkg::*;
;
   logic        clk = 0, resetn = 0, io_wr = 0, io_rd = 0, sel = 0;
   logic        ring = 0, cir = 0, ir = 0, bev = 0, irq_n, oe, slot, wake, pin, seen;
   logic [15:0] base = 16'h0400, io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00, io_rdata, lv = 8'h00;
   logic [2:0]  lk = 3'h0;
   logic [31:0] seed = 32'd48;
   int          errors = 0, checks = 0;
   initial forever #4 clk = ~clk;
   sgel_group i_dut (.clk, .resetn, .power_block_base(base), .io_addr, .io_wr, .io_rd,
      .io_wdata, .io_rdata, .parallel_irq(lv[1]), .serial_two_irq(lv[2]),
      .serial_one_irq(lv[3]), .floppy_irq(lv[4]), .gpio_group_two_irq(lv[5]),
      .gpio_group_one_irq(lv[6]), .watchdog_irq(lv[7]), .mouse_irq(lk[0]),
      .keyboard_irq(lk[1]), .infrared_edge_event(ir), .b_source_event(bev),
      .kbc_port_one_bit_two(lk[2]), .ring_wake_event(ring), .cir_wake_event(cir),
      .serial_frame_select(sel), .group_mgmt_irq_n_o(irq_n), .group_mgmt_irq_n_oe(oe),
      .serirq_slot2_req(slot), .group_to_wake_req(wake));
   sgel_host_model i_host (.clk, .irq_n_o(irq_n), .oe, .slot, .pin_level(pin), .smi_seen(seen));
   function automatic logic [7:0] r8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic act(input logic [7:0] e1, e2);
      return |(e1 & {lv[7:1], 1'b0}) | (e2[1] & lk[1]) | (e2[4] & lk[2]);
   endfunction
   task automatic chk(input string n, input logic [7:0] e, s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // strobes stay up after a task; the next task sets them, so back to back
   // transfers never assign one strobe twice in a time step
   task automatic wr(input logic [15:0] o, input logic [7:0] d);
      io_addr = base + o;
      io_wdata = d;
      io_rd = 0;
      io_wr = 1;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] o, input logic [7:0] e);
      io_addr = base + o;
      io_wr = 0;
      io_rd = 1;
      @(negedge clk);
      chk("rdata", e, io_rdata);
   endtask
   task automatic pulse(ref logic s);
      {io_wr, io_rd} = 2'b00;
      s = 1;
      @(negedge clk);
      s = 0;
   endtask
   task automatic outs(input logic a, input logic [7:0] e2);
      {io_wr, io_rd} = 2'b00;
      repeat (4) @(negedge clk);
      chk("outs", {3'h0, ~(a & e2[7] & ~sel), e2[7] & ~sel, a & e2[7] & sel, a & e2[6],
         a & e2[7]}, {3'h0, irq_n, oe, slot, wake, seen});
      // the host only sees a defined level while the pin is driven
      if (e2[7] & ~sel) chk("pin", {7'h00, ~a}, {7'h00, pin});
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      logic [7:0] e1, e2, d;
      repeat (16) @(negedge clk);
      resetn = 1;
      rd(16'h0014, 8'h00);
      rd(16'h0015, 8'h00);
      rd(16'h0020, 8'h00);
      repeat (40) begin
         e1 = r8();
         e2 = r8();
         lv = r8();
         d = r8();
         lk = d[2:0];
         sel = d[7];
         wr(16'h0015, e2);
         wr(16'h0014, e1);
         rd(16'h0014, e1);
         rd(16'h0015, e2);
         rd(SGEL_OFF_SMI_STS1, {lv[7:1], 1'b0});
         rd(SGEL_OFF_SMI_STS2, {3'h0, lk[2], 2'h0, lk[1:0]});
         outs(act(e1, e2), e2);
      end
      // second power-on reset in mid-run must bring the enables back to zero
      resetn = 0;
      @(negedge clk);
      resetn = 1;
      rd(16'h0014, 8'h00);
      rd(16'h0015, 8'h00);
      outs(1'b0, 8'h00);
      {lv, lk, sel} = '0;
      wr(16'h0014, 8'h01);
      wr(16'h0015, 8'hac);
      pulse(ir);
      pulse(bev);
      outs(1'b1, 8'hac);
      rd(16'h0013, 8'h0c);
      outs(1'b0, 8'hac);
      // event in the clearing read: the set must win
      ir = 1;
      rd(SGEL_OFF_SMI_STS2, 8'h00);
      ir = 0;
      outs(1'b1, 8'hac);
      rd(SGEL_OFF_SMI_STS2, 8'h04);
      pulse(ring);
      outs(1'b1, 8'hac);
      wr(16'h000c, 8'h00);
      outs(1'b1, 8'hac);
      wr(16'h000c, 8'h20);
      outs(1'b0, 8'hac);
      pulse(cir);
      rd(16'h000c, 8'h01);
      outs(1'b1, 8'hac);
      wr(16'h000c, 8'h01);
      outs(1'b0, 8'hac);
      end_of_test();
   end
   initial begin
      #200000;
      errors++;
      end_of_test();
   end
endmodule
